// ===== src/camseq_regs.svh
// register offsets, field positions, reset values and counts of the cam step sequencer
`ifndef CAMSEQ_REGS_SVH
`define CAMSEQ_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CAMSEQ_OFS_CTRL     8'h00
`define CAMSEQ_OFS_STATUS   8'h04
`define CAMSEQ_OFS_TAB_IDX  8'h08
`define CAMSEQ_OFS_TAB_DATA 8'h0C

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CAMSEQ_CTRL_STEPS_LSB 0
`define CAMSEQ_CTRL_STEPS_MSB 5
`define CAMSEQ_CTRL_LOCK_BIT  8
`define CAMSEQ_CTRL_LATCH_BIT 9
`define CAMSEQ_CTRL_CFWD_BIT  10
`define CAMSEQ_CTRL_CREV_BIT  11
`define CAMSEQ_CTRL_CRST_BIT  12

// ----------------------------------------
// status register fields
// ----------------------------------------
`define CAMSEQ_STAT_POS_LSB   0
`define CAMSEQ_STAT_POS_MSB   5
`define CAMSEQ_STAT_OUT_LSB   8
`define CAMSEQ_STAT_OUT_MSB   15
`define CAMSEQ_STAT_RST_BIT   16
`define CAMSEQ_STAT_REJ_BIT   17
`define CAMSEQ_STAT_DIR_BIT   18

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define CAMSEQ_MAX_STEPS      50
`define CAMSEQ_RST_STEPS      6'h32
`define CAMSEQ_RST_POS        6'h01
`define CAMSEQ_RST_CONN       3'h7
`define CAMSEQ_RST_IDX        6'h01

`endif

// ===== src/camseq_pkg.sv
// types shared by the cam step sequencer files
package camseq_pkg;

    // front-panel step edit request
    typedef struct packed {
        logic       wr;
        logic [5:0] step;
        logic [7:0] pattern;
    } camseq_panel_t;

    // register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } camseq_bus_t;

    // step command decoded for one execution cycle
    typedef enum logic [1:0] {
        CAMSEQ_HOLD = 2'b00,
        CAMSEQ_FWD  = 2'b01,
        CAMSEQ_REV  = 2'b10,
        CAMSEQ_INIT = 2'b11
    } camseq_cmd_t;

endpackage

// ===== src/camseq_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module camseq_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             nrst_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule // camseq_sync

`default_nettype wire

// ===== src/camseq_mem.sv
// pattern table: one write port, two registered write-first read ports
`timescale 1ns/1ps
`default_nettype none

module camseq_mem #(
    parameter int DEPTH = 50,
    parameter int WIDTH = 8,
    parameter int AW    = 6
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             nrst_i,
    // write port
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // read ports
    input  wire logic [AW-1:0]    raddr_a_i,
    output logic      [WIDTH-1:0] rdata_a_o,
    input  wire logic [AW-1:0]    raddr_b_i,
    output logic      [WIDTH-1:0] rdata_b_o
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    wire hit_a = we_i && (waddr_i == raddr_a_i);
    wire hit_b = we_i && (waddr_i == raddr_b_i);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            rdata_a_o <= '0;
            rdata_b_o <= '0;
        end else begin
            if (we_i && (int'(waddr_i) < DEPTH)) begin
                mem_reg[waddr_i] <= wdata_i;
            end
            rdata_a_o <= hit_a ? wdata_i : mem_reg[raddr_a_i];
            rdata_b_o <= hit_b ? wdata_i : mem_reg[raddr_b_i];
        end
    end

endmodule // camseq_mem

`default_nettype wire

// ===== src/camseq_top.sv
// cam step sequencer: up/down step counter driving eight cam outputs from a table
// register map
// 0x00 control: [5:0] steps, [8] lock, [9] latching
// 0x00 control: [12:10] reset, reverse, forward connected
// 0x04 status: [5:0] position, [15:8] cam outputs
// 0x04 status: [16] reset level, [17] refused, [18] direction
// 0x04 status: writing one to bit 17 clears it
// 0x08 table index: [5:0] step number, 1 to 50
// 0x0C table data: [7:0] pattern of the indexed step
// defaults: 50 steps, unlocked, not latching, all connected
//
// usage notes
// a refusal in the clearing cycle keeps the flag set
// bus table write beats a same-cycle panel edit
// reset pin acts every clock, edges only on ticks
// warm start returns to step one unless latching
// a position above a lowered count wraps on forward
`timescale 1ns/1ps
`default_nettype none

`include "camseq_regs.svh"

module camseq_top
    import camseq_pkg::*;
#(
    parameter int MAX_STEPS = `CAMSEQ_MAX_STEPS,
    parameter int OUT_W     = 8
) (
    // clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                nrst_i,
    // program execution cycle
    input  wire logic                cycle_tick_i,
    input  wire logic                warm_start_i,
    // cam control pins
    input  wire logic                fwd_i,
    input  wire logic                rev_i,
    input  wire logic                cam_rst_i,
    // front-panel edit path
    input  wire camseq_panel_t       panel_i,
    output logic                     panel_ack_o,
    output logic                     panel_rej_o,
    // register port
    input  wire camseq_bus_t         bus_i,
    output logic      [31:0]         rdata_o,
    // cam results
    output logic      [OUT_W-1:0]    cam_out_o,
    output logic      [5:0]          position_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // step number within 1 to the table depth
    function automatic logic step_ok(input logic [5:0] s);
        return (s != 6'h00) && (int'(s) <= MAX_STEPS);
    endfunction

    // table address of a step number
    function automatic logic [5:0] step_addr(input logic [5:0] s);
        return s - 6'h01;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // pins cross into this clock through two flops
    logic [2:0] pins_sync;

    camseq_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .async_i   ({cam_rst_i, rev_i, fwd_i}),
        .sync_o    (pins_sync)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // configuration
    logic [5:0]  steps_reg;
    logic [5:0]  steps_next;
    logic        lock_reg;
    logic        lock_next;
    logic        latch_reg;
    logic        latch_next;
    logic [2:0]  conn_reg;
    logic [2:0]  conn_next;
    logic [5:0]  idx_reg;
    logic [5:0]  idx_next;

    // stepping
    logic [5:0]  pos_reg;
    logic [5:0]  pos_next;
    logic        dir_reg;
    logic        dir_next;

    // pin history
    logic        fwd_prev_reg;
    logic        fwd_prev_next;
    logic        rev_prev_reg;
    logic        rev_prev_next;

    // panel refusal and read data
    logic        rej_reg;
    logic        rej_next;
    logic [31:0] rdata_next;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // unmapped addresses select nothing
    wire sel_ctrl = bus_i.addr == `CAMSEQ_OFS_CTRL;
    wire sel_stat = bus_i.addr == `CAMSEQ_OFS_STATUS;
    wire sel_idx  = bus_i.addr == `CAMSEQ_OFS_TAB_IDX;
    wire sel_data = bus_i.addr == `CAMSEQ_OFS_TAB_DATA;

    wire wr_ctrl  = bus_i.wr && sel_ctrl;
    wire wr_stat  = bus_i.wr && sel_stat;
    wire wr_idx   = bus_i.wr && sel_idx;
    wire wr_data  = bus_i.wr && sel_data;

    wire [5:0] wr_steps = bus_i.wdata[`CAMSEQ_CTRL_STEPS_MSB:`CAMSEQ_CTRL_STEPS_LSB];
    wire [5:0] wr_idxv  = bus_i.wdata[5:0];

    // ----------------------------------------
    // configuration
    // ----------------------------------------
    // out-of-range step counts are ignored, the old count stays
    assign steps_next = (wr_ctrl && step_ok(wr_steps)) ? wr_steps : steps_reg;
    assign lock_next  = wr_ctrl ? bus_i.wdata[`CAMSEQ_CTRL_LOCK_BIT]  : lock_reg;
    assign latch_next = wr_ctrl ? bus_i.wdata[`CAMSEQ_CTRL_LATCH_BIT] : latch_reg;
    assign conn_next  = wr_ctrl ? {bus_i.wdata[`CAMSEQ_CTRL_CRST_BIT],
                                   bus_i.wdata[`CAMSEQ_CTRL_CREV_BIT],
                                   bus_i.wdata[`CAMSEQ_CTRL_CFWD_BIT]} : conn_reg;
    assign idx_next   = (wr_idx && step_ok(wr_idxv)) ? wr_idxv : idx_reg;

    // ----------------------------------------
    // input conditioning
    // ----------------------------------------
    // an unconnected input is forced inactive
    wire fwd_lvl = pins_sync[0] && conn_reg[0];
    wire rev_lvl = pins_sync[1] && conn_reg[1];
    wire rst_lvl = pins_sync[2] && conn_reg[2];

    // history moves only once per execution cycle
    assign fwd_prev_next = cycle_tick_i ? fwd_lvl : fwd_prev_reg;
    assign rev_prev_next = cycle_tick_i ? rev_lvl : rev_prev_reg;

    wire fwd_rise = cycle_tick_i && fwd_lvl && !fwd_prev_reg;
    wire rev_rise = cycle_tick_i && rev_lvl && !rev_prev_reg;

    // ----------------------------------------
    // step command
    // ----------------------------------------
    wire power_init = warm_start_i && !latch_reg;

    camseq_cmd_t cmd;

    // reset and unlatched power return beat both edges, forward beats reverse
    assign cmd = (rst_lvl || power_init) ? CAMSEQ_INIT :
                 fwd_rise                ? CAMSEQ_FWD  :
                 rev_rise                ? CAMSEQ_REV  :
                                           CAMSEQ_HOLD;

    // at or above the count, so a lowered count still wraps
    wire at_max = pos_reg >= steps_reg;
    wire at_one = pos_reg <= `CAMSEQ_RST_POS;

    wire [5:0] pos_inc = at_max ? `CAMSEQ_RST_POS : pos_reg + 6'h01;
    wire [5:0] pos_dec = at_one ? steps_reg : pos_reg - 6'h01;

    always_comb begin
        unique case (cmd)
            CAMSEQ_INIT: pos_next = `CAMSEQ_RST_POS;
            CAMSEQ_FWD:  pos_next = pos_inc;
            CAMSEQ_REV:  pos_next = pos_dec;
            CAMSEQ_HOLD: pos_next = pos_reg;
        endcase
    end

    assign dir_next = (cmd == CAMSEQ_FWD) ? 1'b1 :
                      (cmd == CAMSEQ_REV) ? 1'b0 : dir_reg;

    // ----------------------------------------
    // front-panel edits
    // ----------------------------------------
    // the panel carries a step number and pattern only, never the count
    wire panel_valid = panel_i.wr && step_ok(panel_i.step);
    // a same-cycle bus table write takes the port
    wire panel_take  = panel_valid && !lock_reg && !wr_data;

    assign panel_ack_o = panel_take;
    assign panel_rej_o = panel_i.wr && !panel_take;

    // sticky refusal flag, set wins over a write-one clear
    assign rej_next = panel_rej_o ? 1'b1 :
                      (wr_stat && bus_i.wdata[`CAMSEQ_STAT_REJ_BIT]) ? 1'b0 : rej_reg;

    // ----------------------------------------
    // pattern table
    // ----------------------------------------
    wire        tab_we    = wr_data || panel_take;
    wire [5:0]  tab_waddr = wr_data ? step_addr(idx_reg) : step_addr(panel_i.step);
    wire [7:0]  tab_wdata = wr_data ? bus_i.wdata[7:0] : panel_i.pattern;
    wire [7:0]  tab_rd;

    // reading at the next position keeps outputs in step with it
    camseq_mem #(
        .DEPTH (MAX_STEPS),
        .WIDTH (OUT_W),
        .AW    (6)
    ) u_mem (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .we_i      (tab_we),
        .waddr_i   (tab_waddr),
        .wdata_i   (tab_wdata),
        .raddr_a_i (step_addr(pos_next)),
        .rdata_a_o (cam_out_o),
        .raddr_b_i (step_addr(idx_next)),
        .rdata_b_o (tab_rd)
    );

    // ----------------------------------------
    // read data
    // ----------------------------------------
    wire [31:0] ctrl_word = {19'h00000, conn_reg[2], conn_reg[1], conn_reg[0],
                             latch_reg, lock_reg, 2'h0, steps_reg};
    wire [31:0] stat_word = {13'h0000, dir_reg, rej_reg, rst_lvl,
                             cam_out_o, 2'h0, pos_reg};

    wire [31:0] idx_word  = {26'h0000000, idx_reg};
    wire [31:0] data_word = {24'h000000, tab_rd};

    assign rdata_next = !bus_i.rd ? 32'h00000000 :
                        sel_ctrl  ? ctrl_word :
                        sel_stat  ? stat_word :
                        sel_idx   ? idx_word :
                        sel_data  ? data_word :
                                    32'h00000000;

    assign position_o = pos_reg;

    // ----------------------------------------
    // configuration state
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            steps_reg <= `CAMSEQ_RST_STEPS;
            lock_reg  <= 1'b0;
            latch_reg <= 1'b0;
            conn_reg  <= `CAMSEQ_RST_CONN;
            idx_reg   <= `CAMSEQ_RST_IDX;
        end else begin
            steps_reg <= steps_next;
            lock_reg  <= lock_next;
            latch_reg <= latch_next;
            conn_reg  <= conn_next;
            idx_reg   <= idx_next;
        end
    end

    // ----------------------------------------
    // position
    // ----------------------------------------
    // reset value is the initial step
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pos_reg <= `CAMSEQ_RST_POS;
        end else begin
            pos_reg <= pos_next;
        end
    end

    // ----------------------------------------
    // last direction
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dir_reg <= 1'b1;
        end else begin
            dir_reg <= dir_next;
        end
    end

    // ----------------------------------------
    // pin history
    // ----------------------------------------
    // last level seen at a tick
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fwd_prev_reg <= 1'b0;
            rev_prev_reg <= 1'b0;
        end else begin
            fwd_prev_reg <= fwd_prev_next;
            rev_prev_reg <= rev_prev_next;
        end
    end

    // ----------------------------------------
    // refusal flag
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rej_reg <= 1'b0;
        end else begin
            rej_reg <= rej_next;
        end
    end

    // ----------------------------------------
    // read data register
    // ----------------------------------------
    // zero unless a read was strobed
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= rdata_next;
        end
    end

endmodule // camseq_top

`default_nettype wire

// ===== verif/camseq_chk_assertions.sv
// port-level assertions of the cam step sequencer
`timescale 1ns/1ps
`default_nettype none
`include "camseq_regs.svh"
module camseq_chk
    import camseq_pkg::*;
#(
    parameter int MAX_STEPS = 50,
    parameter int OUT_W     = 8
) (
    // watched inputs
    input wire logic             clk_sys_i,
    input wire logic             nrst_i,
    input wire logic             cycle_tick_i,
    input wire logic             warm_start_i,
    input wire logic             fwd_i,
    input wire logic             rev_i,
    input wire logic             cam_rst_i,
    input wire camseq_panel_t    panel_i,
    input wire camseq_bus_t      bus_i,
    // watched outputs
    input wire logic             panel_ack_o,
    input wire logic             panel_rej_o,
    input wire logic [31:0]      rdata_o,
    input wire logic [OUT_W-1:0] cam_out_o,
    input wire logic [5:0]       position_o
);
    logic [5:0] steps_reg;
    logic       lock_reg;
    logic       latch_reg;
    logic       rconn_reg;
    wire logic  ctrl_wr  = bus_i.wr && bus_i.addr == `CAMSEQ_OFS_CTRL;
    wire logic  tab_wr   = bus_i.wr && bus_i.addr == `CAMSEQ_OFS_TAB_DATA;
    wire logic  steps_ok = bus_i.wdata[5:0] != 6'h00 && bus_i.wdata[5:0] <= 6'h32;
    wire logic  pstep_ok = panel_i.step != 6'h00 && panel_i.step <= 6'h32;

    // shadow of the steps, lock, latching and reset-connect control fields
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            steps_reg <= `CAMSEQ_RST_STEPS;
            lock_reg  <= 1'b0;
            latch_reg <= 1'b0;
            rconn_reg <= 1'b1;
        end else if (ctrl_wr) begin
            if (steps_ok) begin
                steps_reg <= bus_i.wdata[5:0];
            end
            lock_reg  <= bus_i.wdata[`CAMSEQ_CTRL_LOCK_BIT];
            latch_reg <= bus_i.wdata[`CAMSEQ_CTRL_LATCH_BIT];
            rconn_reg <= bus_i.wdata[`CAMSEQ_CTRL_CRST_BIT];
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    property p_pos_range;
        position_o >= 6'h01 && position_o <= MAX_STEPS;
    endproperty
    a_pos_range: assert property (p_pos_range) else $error("position out of range");
    property p_rst_hold;
        rconn_reg && cam_rst_i [*3] |=> position_o == 6'h01;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("position not held at one");
    property p_tick_only;
        $changed(position_o) && position_o != 6'h01 |-> $past(cycle_tick_i);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("position moved without tick");
    property p_one_step;
        $changed(position_o) |-> position_o == $past(position_o) + 6'h01 || position_o == $past(position_o) - 6'h01
            || position_o == 6'h01 || ($past(position_o) == 6'h01 && position_o == steps_reg);
    endproperty
    a_one_step: assert property (p_one_step) else $error("position jumped");
    property p_lock_rej;
        panel_i.wr && lock_reg |-> panel_rej_o && !panel_ack_o;
    endproperty
    a_lock_rej: assert property (p_lock_rej) else $error("locked edit taken");
    property p_step_rej;
        panel_i.wr && !pstep_ok |-> panel_rej_o && !panel_ack_o;
    endproperty
    a_step_rej: assert property (p_step_rej) else $error("bad step edit taken");
    property p_edit_ack;
        panel_i.wr && !lock_reg && pstep_ok && !tab_wr |-> panel_ack_o && !panel_rej_o;
    endproperty
    a_edit_ack: assert property (p_edit_ack) else $error("valid edit not taken");
    property p_warm;
        warm_start_i && !latch_reg |=> position_o == 6'h01;
    endproperty
    a_warm: assert property (p_warm) else $error("position kept without latching");
endmodule // camseq_chk

bind camseq_top camseq_chk #(.MAX_STEPS(MAX_STEPS), .OUT_W(OUT_W)) i_camseq_chk (.clk_sys_i, .nrst_i,
    .cycle_tick_i, .warm_start_i, .fwd_i, .rev_i, .cam_rst_i, .panel_i, .bus_i, .panel_ack_o, .panel_rej_o,
    .rdata_o, .cam_out_o, .position_o);
`default_nettype wire

// ===== verif/camseq_prog_model.sv
// model of the surrounding relay program: execution tick and pin levels
`timescale 1ns/1ps
`default_nettype none
module camseq_prog_model #(
    parameter int TICK_DIV = 4
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    // requested pin levels
    input  wire logic fwd_req_i,
    input  wire logic rev_req_i,
    input  wire logic rst_req_i,
    // to the sequencer
    output logic      cycle_tick_o,
    output logic      fwd_o,
    output logic      rev_o,
    output logic      cam_rst_o
);
    logic [3:0] cnt_reg;
    wire logic  last = cnt_reg == 4'(TICK_DIV - 1);

    // one execution cycle every TICK_DIV clocks
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg      <= 4'h0;
            cycle_tick_o <= 1'b0;
            fwd_o        <= 1'b0;
            rev_o        <= 1'b0;
            cam_rst_o    <= 1'b0;
        end else begin
            cnt_reg      <= last ? 4'h0 : cnt_reg + 4'h1;
            cycle_tick_o <= last;
            fwd_o        <= fwd_req_i;
            rev_o        <= rev_req_i;
            cam_rst_o    <= rst_req_i;
        end
    end
endmodule // camseq_prog_model
`default_nettype wire

// ===== verif/test_cam_step_sequencer.sv
// self-checking testbench of the cam step sequencer
`timescale 1ns/1ps
`default_nettype none
`include "camseq_regs.svh"
module test_cam_step_sequencer;
    import camseq_pkg::*;
    logic             clk_sys_i;
    logic             nrst_i;
    logic             warm_start_i;
    logic             fwd_req;
    logic             rev_req;
    logic             rst_req;
    camseq_panel_t    panel_i;
    camseq_bus_t      bus_i;
    wire logic        tick, fwd, rev, crst, ack, rej;
    wire logic [31:0] rdata;
    wire logic [7:0]  cam_out;
    wire logic [5:0]  pos;
    logic [7:0]       pt [0:63] = '{default: 8'h00};
    int               n_errors, tests_run;

    camseq_prog_model i_camseq_prog_model (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .fwd_req_i(fwd_req),
        .rev_req_i(rev_req), .rst_req_i(rst_req), .cycle_tick_o(tick), .fwd_o(fwd), .rev_o(rev), .cam_rst_o(crst));
    camseq_top i_camseq_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cycle_tick_i(tick), .warm_start_i(warm_start_i),
        .fwd_i(fwd), .rev_i(rev), .cam_rst_i(crst), .panel_i(panel_i), .panel_ack_o(ack), .panel_rej_o(rej),
        .bus_i(bus_i), .rdata_o(rdata), .cam_out_o(cam_out), .position_o(pos));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        bus_i <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_i);
        bus_i <= '0;
        @(posedge clk_sys_i);
    endtask
    task automatic br(input logic [7:0] a, input logic [31:0] e);
        bus_i <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk_sys_i);
        bus_i <= '0;
        #1 chk(rdata, e);
        @(posedge clk_sys_i);
    endtask
    // pins held over enough ticks, then released
    task automatic st(input logic f, input logic r, input logic x, input logic [5:0] e);
        fwd_req <= f;
        rev_req <= r;
        rst_req <= x;
        repeat (10) @(posedge clk_sys_i);
        fwd_req <= 1'b0;
        rev_req <= 1'b0;
        rst_req <= 1'b0;
        #1 chk(pos, e);
        chk(cam_out, pt[e]);
        repeat (10) @(posedge clk_sys_i);
    endtask
    task automatic pe(input logic [5:0] s, input logic [7:0] p, input logic e);
        panel_i <= '{1'b1, s, p};
        #1 chk(ack, e);
        chk(rej, !e);
        @(posedge clk_sys_i);
        panel_i <= '0;
        if (e) pt[s] = p;
        @(posedge clk_sys_i);
        #1 chk(cam_out, pt[pos]);
        @(posedge clk_sys_i);
    endtask
    task automatic wm(input logic [5:0] e);
        warm_start_i <= 1'b1;
        @(posedge clk_sys_i);
        warm_start_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 chk(pos, e);
        @(posedge clk_sys_i);
    endtask
    task automatic done(input string n);
        $display("test %s finished, mismatches so far %0d", n, n_errors);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        nrst_i = 1'b0;
        warm_start_i = 1'b0;
        fwd_req = 1'b0;
        rev_req = 1'b0;
        rst_req = 1'b0;
        panel_i = '0;
        bus_i = '0;
        n_errors = 0;
        tests_run = 0;
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        br(`CAMSEQ_OFS_CTRL, 32'h0000_1C32);
        chk(pos, 32'h1);
        done("reset");
        bw(`CAMSEQ_OFS_CTRL, 32'h0000_1C03);
        for (int i = 1; i <= 3; i++) begin
            pt[i] = {i[3:0], ~i[3:0]};
            bw(`CAMSEQ_OFS_TAB_IDX, 32'(i));
            bw(`CAMSEQ_OFS_TAB_DATA, 32'(pt[i]));
        end
        bw(`CAMSEQ_OFS_TAB_IDX, 32'h2);
        br(`CAMSEQ_OFS_TAB_DATA, 32'h2D);
        br(8'h10, 32'h0);
        done("table");
        st(1'b1, 1'b0, 1'b0, 6'h02);
        st(1'b1, 1'b0, 1'b0, 6'h03);
        st(1'b1, 1'b0, 1'b0, 6'h01);
        st(1'b0, 1'b1, 1'b0, 6'h03);
        st(1'b0, 1'b1, 1'b0, 6'h02);
        br(`CAMSEQ_OFS_STATUS, 32'h0000_2D02);
        st(1'b1, 1'b1, 1'b0, 6'h03);
        st(1'b1, 1'b0, 1'b1, 6'h01);
        st(1'b1, 1'b0, 1'b0, 6'h02);
        bw(`CAMSEQ_OFS_CTRL, 32'h0000_0003);
        st(1'b1, 1'b1, 1'b1, 6'h02);
        bw(`CAMSEQ_OFS_CTRL, 32'h0000_1C03);
        done("stepping");
        pe(6'h02, 8'h55, 1'b1);
        pe(6'h00, 8'hFF, 1'b0);
        pe(6'h33, 8'hFF, 1'b0);
        bw(`CAMSEQ_OFS_CTRL, 32'h0000_1D03);
        pe(6'h02, 8'hAA, 1'b0);
        br(`CAMSEQ_OFS_STATUS, 32'h0006_5502);
        bw(`CAMSEQ_OFS_STATUS, 32'h0002_0000);
        br(`CAMSEQ_OFS_STATUS, 32'h0004_5502);
        bw(`CAMSEQ_OFS_CTRL, 32'h0000_1C00);
        br(`CAMSEQ_OFS_CTRL, 32'h0000_1C03);
        bw(`CAMSEQ_OFS_CTRL, 32'h0000_1C33);
        br(`CAMSEQ_OFS_CTRL, 32'h0000_1C03);
        done("panel");
        wm(6'h01);
        st(1'b1, 1'b0, 1'b0, 6'h02);
        bw(`CAMSEQ_OFS_CTRL, 32'h0000_1E03);
        wm(6'h02);
        done("latching");
        wrap_up;
    end

    // hang guard
    initial begin
        #2_000_000;
        n_errors++;
        wrap_up;
    end
endmodule // test_cam_step_sequencer
`default_nettype wire
